// [common/pms_consts.svh]
/*
 Register offsets, field positions and reset values of the power-mode
 sequencer. Assumes a 4-bit AXI4-Lite byte address.
*/
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
`define PMS_ADDR_W 4
`define PMS_ADDR_CTRL 4'h0
`define PMS_ADDR_WAKE_EN 4'h4
`define PMS_ADDR_STATUS 4'h8
`define PMS_BIT_SLEEP_SEL 0
`define PMS_BIT_LOW_SPEED 1
`define PMS_BIT_DIRECT 2
`define PMS_BIT_STANDBY 3
`define PMS_BIT_RTC_TB 4
`define PMS_BIT_WDT_OSC 5
`define PMS_CTRL_W 6
`define PMS_WAKE_W 10
`define PMS_CTRL_RESET 6'h00
`define PMS_WAKE_EN_RESET 10'h000
`define PMS_RESP_OKAY 2'h0
`define PMS_RESP_SLVERR 2'h2
`endif

// [common/pms_pkg.sv]
/*
 Types of the power-mode sequencer.
 Assumes nothing of its surroundings.
*/
package pms_pkg;
	typedef enum logic [2:0] {
		PMS_ACTIVE = 3'h0,
		PMS_SLEEP = 3'h1,
		PMS_SUBSLEEP = 3'h3,
		PMS_SUBACTIVE = 3'h2,
		PMS_STANDBY = 3'h6,
		PMS_RESET = 3'h7
	} pms_state_t;
endpackage : pms_pkg

// [common/pms_regs_if.sv]
/*
 Carrier between the register slave and the sequencer core.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`include "pms_consts.svh"
interface pms_regs_if;
	logic [`PMS_CTRL_W-1:0] ctrl;
	logic [`PMS_WAKE_W-1:0] wake_en;
	logic [31:0] status;
	modport slave (output ctrl, output wake_en, input status);
	modport core (input ctrl, input wake_en, output status);
endinterface : pms_regs_if

// [core/pms_axil.sv]
/*
 AXI4-Lite register slave of the power-mode sequencer.
 Assumes one master with at most one write and one read in flight.
*/
`timescale 1ns/1ps
`include "pms_consts.svh"
module pms_axil (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [`PMS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`PMS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	pms_regs_if.slave regs
);
	logic aw_held;
	logic w_held;
	logic [`PMS_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;

	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign next_aw_held = (aw_held || aw_take) && !do_write;
	assign next_w_held = (w_held || w_take) && !do_write;
	assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
	assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

	// Write channels, taken in either order
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (aw_take)
				aw_addr <= s_axi_awaddr;
			if (w_take)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready <= !next_w_held && !next_bvalid;
			s_axi_bvalid <= next_bvalid;
		end
	end

	// Register update and write response
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			regs.ctrl <= `PMS_CTRL_RESET;
			regs.wake_en <= `PMS_WAKE_EN_RESET;
			s_axi_bresp <= `PMS_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bresp <= `PMS_RESP_OKAY;
			case (aw_addr)
				`PMS_ADDR_CTRL:
					if (w_strb[0])
						regs.ctrl <= w_data[`PMS_CTRL_W-1:0];
				`PMS_ADDR_WAKE_EN:
				begin
					if (w_strb[0])
						regs.wake_en[7:0] <= w_data[7:0];
					if (w_strb[1])
						regs.wake_en[9:8] <= w_data[9:8];
				end
				`PMS_ADDR_STATUS: ;
				default:
					s_axi_bresp <= `PMS_RESP_SLVERR;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `PMS_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (ar_take)
			begin
				s_axi_rresp <= `PMS_RESP_OKAY;
				case (s_axi_araddr)
					`PMS_ADDR_CTRL:
						s_axi_rdata <= {26'h0, regs.ctrl};
					`PMS_ADDR_WAKE_EN:
						s_axi_rdata <= {22'h0, regs.wake_en};
					`PMS_ADDR_STATUS:
						s_axi_rdata <= regs.status;
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `PMS_RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule : pms_axil

// [core/pms_top.sv]
/*
 Power-mode sequencer: moves the chip between active, subactive, sleep,
 subsleep, standby and the reset state, and drives per-mode enables.
 Assumes the CPU pulses sleep_exec at the instruction boundary after
 SLEEP, and that the interrupt controller reports enabled internal
 requests on periph_irq_req. Pins are asynchronous.
*/
// Design decisions made here: register access over AXI4-Lite and the address map.
// Operation
// - SLEEP in execution mode enters halt mode
// - Accepted interrupt in halt resumes execution
// - Direct active/subactive move without halting
// - Direct active-to-active, subactive-to-subactive allowed
// - Reset pin forces reset state
// - Select bits pick halt and resume modes
// - Direct, both bits low: stay active
// - Direct with low-speed bit: subactive
// - Transition with sleep-select resets peripherals
// - Oscillator and CPU enables per mode
// - Ports held; standby floats; wake inputs live
// - RTC runs if time-base selected
// - Watchdog holds unless internal oscillator clocks
// - Direct transition raises its exception
// - Sleep/subsleep exit follows low-speed bit; standby exits to active
// - Masked or disabled interrupts never wake
// - Disabled direct interrupt falls to halt
`timescale 1ns/1ps
`include "pms_consts.svh"
module pms_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic external_reset_pin_n,
	input wire logic [3:0] external_irq_inputs,
	input wire logic [5:0] wakeup_inputs,
	input wire logic sleep_exec,
	input wire logic ccr_i_mask,
	input wire logic dt_irq_enable,
	input wire logic periph_irq_req,
	input wire logic [`PMS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`PMS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [2:0] mode,
	output logic chip_reset,
	output logic main_osc_en,
	output logic sub_osc_en,
	output logic cpu_run,
	output logic port_hiz,
	output logic rtc_run,
	output logic wdt_run,
	output logic periph_reset,
	output logic dt_exc_req,
	output logic wake_exc_req,
	output logic [9:0] wake_pins
);
	pms_regs_if regs ();
	logic [10:0] pin_meta;
	logic [10:0] pin_sync;
	logic pin_rst;
	logic [9:0] pins;
	logic sleep_sel;
	logic low_speed;
	logic direct_on;
	logic standby_sel;
	logic rtc_tb;
	logic wdt_osc;
	logic wake;
	logic dt_ok;
	logic exec_mode;
	logic halt_mode;
	logic next_dt;
	logic next_wake;
	pms_pkg::pms_state_t state;
	pms_pkg::pms_state_t next_state;

	pms_axil u_axil (
		.mclk(mclk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regs(regs)
	);

	// Two-stage pin synchroniser; reset pin idles high
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_meta <= 11'h001;
			pin_sync <= 11'h001;
		end
		else
		begin
			pin_meta <= {wakeup_inputs, external_irq_inputs,
				external_reset_pin_n};
			pin_sync <= pin_meta;
		end
	end

	assign pin_rst = !pin_sync[0];
	assign pins = pin_sync[10:1];
	assign sleep_sel = regs.ctrl[`PMS_BIT_SLEEP_SEL];
	assign low_speed = regs.ctrl[`PMS_BIT_LOW_SPEED];
	assign direct_on = regs.ctrl[`PMS_BIT_DIRECT];
	assign standby_sel = regs.ctrl[`PMS_BIT_STANDBY];
	assign rtc_tb = regs.ctrl[`PMS_BIT_RTC_TB];
	assign wdt_osc = regs.ctrl[`PMS_BIT_WDT_OSC];
	assign exec_mode = (state == pms_pkg::PMS_ACTIVE) ||
		(state == pms_pkg::PMS_SUBACTIVE);
	assign halt_mode = (state == pms_pkg::PMS_SLEEP) ||
		(state == pms_pkg::PMS_SUBSLEEP) ||
		(state == pms_pkg::PMS_STANDBY);
	// Wake only by unmasked, enabled requests
	assign wake = !ccr_i_mask &&
		(periph_irq_req || |(pins & regs.wake_en));
	// Direct move needs its interrupt enabled and unmasked
	assign dt_ok = dt_irq_enable && !ccr_i_mask;

	assign regs.status = {13'h0, pins, wdt_run, rtc_run, port_hiz,
		cpu_run, main_osc_en, 1'b0, mode};

	// Next mode
	always_comb
	begin
		next_state = state;
		next_dt = 1'b0;
		next_wake = 1'b0;
		if (pin_rst)
			next_state = pms_pkg::PMS_RESET;
		else
		begin
			case (state)
				pms_pkg::PMS_RESET:
					next_state = pms_pkg::PMS_ACTIVE;
				pms_pkg::PMS_ACTIVE, pms_pkg::PMS_SUBACTIVE:
				begin
					if (sleep_exec)
					begin
						if (direct_on && dt_ok && low_speed)
						begin
							next_state = pms_pkg::PMS_SUBACTIVE;
							next_dt = 1'b1;
						end
						else if (direct_on && dt_ok && !sleep_sel)
						begin
							next_state = pms_pkg::PMS_ACTIVE;
							next_dt = 1'b1;
						end
						else if (direct_on)
							next_state = sleep_sel ? pms_pkg::PMS_SUBSLEEP :
								pms_pkg::PMS_SLEEP;
						else if (standby_sel)
							next_state = pms_pkg::PMS_STANDBY;
						else
							next_state = sleep_sel ? pms_pkg::PMS_SUBSLEEP :
								pms_pkg::PMS_SLEEP;
					end
				end
				pms_pkg::PMS_SLEEP, pms_pkg::PMS_SUBSLEEP:
				begin
					if (wake)
					begin
						next_state = low_speed ? pms_pkg::PMS_SUBACTIVE :
							pms_pkg::PMS_ACTIVE;
						next_wake = 1'b1;
					end
				end
				pms_pkg::PMS_STANDBY:
				begin
					if (wake)
					begin
						next_state = pms_pkg::PMS_ACTIVE;
						next_wake = 1'b1;
					end
				end
				default:
					next_state = pms_pkg::PMS_RESET;
			endcase
		end
	end

	// Mode register
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state <= pms_pkg::PMS_ACTIVE;
		else
			state <= next_state;
	end

	// Events and mode outputs
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			mode <= 3'h0;
			chip_reset <= 1'b0;
			periph_reset <= 1'b0;
			dt_exc_req <= 1'b0;
			wake_exc_req <= 1'b0;
			wake_pins <= 10'h000;
		end
		else
		begin
			mode <= next_state;
			chip_reset <= next_state == pms_pkg::PMS_RESET;
			periph_reset <= (next_state != state) && sleep_sel;
			dt_exc_req <= next_dt;
			wake_exc_req <= next_wake;
			wake_pins <= pins;
		end
	end

	// Clock, CPU and peripheral enables
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			main_osc_en <= 1'b1;
			sub_osc_en <= 1'b1;
			cpu_run <= 1'b1;
			port_hiz <= 1'b0;
			rtc_run <= 1'b1;
			wdt_run <= 1'b1;
		end
		else
		begin
			main_osc_en <= (next_state == pms_pkg::PMS_ACTIVE) ||
				(next_state == pms_pkg::PMS_SLEEP) ||
				(next_state == pms_pkg::PMS_RESET);
			sub_osc_en <= 1'b1;
			cpu_run <= (next_state == pms_pkg::PMS_ACTIVE) ||
				(next_state == pms_pkg::PMS_SUBACTIVE);
			port_hiz <= next_state == pms_pkg::PMS_STANDBY;
			rtc_run <= (next_state == pms_pkg::PMS_ACTIVE) ||
				(next_state == pms_pkg::PMS_SLEEP) || rtc_tb;
			wdt_run <= (next_state == pms_pkg::PMS_ACTIVE) ||
				(next_state == pms_pkg::PMS_SLEEP) || wdt_osc;
		end
	end

	sequence s_sleep_cmd;
		exec_mode && sleep_exec && !pin_rst;
	endsequence

	sequence s_halt_wake;
		(state == pms_pkg::PMS_SLEEP || state == pms_pkg::PMS_SUBSLEEP)
			&& wake && !pin_rst;
	endsequence

	property p_halt_entry;
		@(posedge mclk) disable iff (rst)
		s_sleep_cmd ##0 (!direct_on && !standby_sel && !sleep_sel)
			|=> state == pms_pkg::PMS_SLEEP && cpu_run == 1'b0;
	endproperty
	a_halt_entry: assert property (p_halt_entry)
		else $error("sleep not entered");

	property p_standby;
		@(posedge mclk) disable iff (rst)
		s_sleep_cmd ##0 (!direct_on && standby_sel)
			|=> state == pms_pkg::PMS_STANDBY ##1 port_hiz;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby not entered");

	property p_wake;
		@(posedge mclk) disable iff (rst)
		s_halt_wake |=> wake_exc_req && state ==
			(low_speed ? pms_pkg::PMS_SUBACTIVE : pms_pkg::PMS_ACTIVE);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wrong resume mode");

	property p_masked;
		@(posedge mclk) disable iff (rst)
		halt_mode && ccr_i_mask && !pin_rst |=> $stable(state);
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked interrupt woke");

	property p_direct_sub;
		@(posedge mclk) disable iff (rst)
		s_sleep_cmd ##0 (direct_on && dt_ok && low_speed)
			|=> state == pms_pkg::PMS_SUBACTIVE && dt_exc_req
			##1 !dt_exc_req;
	endproperty
	a_direct_sub: assert property (p_direct_sub)
		else $error("direct to subactive failed");

	property p_direct_act;
		@(posedge mclk) disable iff (rst)
		s_sleep_cmd ##0 (direct_on && dt_ok && !low_speed && !sleep_sel)
			|=> state == pms_pkg::PMS_ACTIVE && dt_exc_req && cpu_run;
	endproperty
	a_direct_act: assert property (p_direct_act)
		else $error("direct to active failed");

	property p_direct_off;
		@(posedge mclk) disable iff (rst)
		s_sleep_cmd ##0 (direct_on && !dt_ok)
			|=> halt_mode && !dt_exc_req;
	endproperty
	a_direct_off: assert property (p_direct_off)
		else $error("disabled direct move not halted");

	property p_pin_reset;
		@(posedge mclk) disable iff (rst)
		!external_reset_pin_n ##1 !external_reset_pin_n
			|=> ##1 state == pms_pkg::PMS_RESET && chip_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("reset pin ignored");

	property p_periph_reset;
		@(posedge mclk) disable iff (rst)
		state != $past(state) && $past(sleep_sel) |-> periph_reset;
	endproperty
	a_periph_reset: assert property (p_periph_reset)
		else $error("peripheral reset missing");

	property p_main_osc;
		@(posedge mclk) disable iff (rst)
		(state == pms_pkg::PMS_SUBACTIVE || halt_mode)
			|-> main_osc_en == (state == pms_pkg::PMS_SLEEP);
	endproperty
	a_main_osc: assert property (p_main_osc)
		else $error("main oscillator wrong");

	property p_slow_timers;
		@(posedge mclk) disable iff (rst)
		(state == pms_pkg::PMS_SUBACTIVE || state == pms_pkg::PMS_SUBSLEEP)
			|-> rtc_run == $past(rtc_tb) && wdt_run == $past(wdt_osc);
	endproperty
	a_slow_timers: assert property (p_slow_timers)
		else $error("rtc or watchdog enable wrong");

	property p_no_spurious;
		@(posedge mclk) disable iff (rst)
		exec_mode && !sleep_exec && !pin_rst |=> $stable(state);
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("mode changed without SLEEP");
endmodule : pms_top

// [testbench/pms_cpu_model.sv]
/*
 Behavioural CPU core and interrupt controller facing the sequencer.
 Assumes the sequencer samples its inputs on the rising edge of mclk.
*/
`timescale 1ns/1ps
module pms_cpu_model (
	input wire logic mclk,
	input wire logic cpu_run,
	output logic sleep_exec,
	output logic ccr_i_mask,
	output logic dt_irq_enable,
	output logic periph_irq_req
);
	initial
	begin
		sleep_exec = 1'b0;
		ccr_i_mask = 1'b0;
		dt_irq_enable = 1'b0;
		periph_irq_req = 1'b0;
	end

	// Instruction boundary pulse; a halted CPU issues nothing
	task exec_sleep;
		@(posedge mclk);
		if (cpu_run === 1'b1)
			sleep_exec <= 1'b1;
		@(posedge mclk);
		sleep_exec <= 1'b0;
	endtask : exec_sleep

	// Request held n cycles, then withdrawn
	task raise_irq(input int n);
		@(posedge mclk);
		periph_irq_req <= 1'b1;
		repeat (n) @(posedge mclk);
		periph_irq_req <= 1'b0;
	endtask : raise_irq

	task set_flags(input logic m, input logic d);
		@(posedge mclk);
		ccr_i_mask <= m;
		dt_irq_enable <= d;
	endtask : set_flags
endmodule : pms_cpu_model

// [testbench/power_mode_sequencer_tb.sv]
/*
 Self-checking bench of the power-mode sequencer.
 Assumes the design files and the CPU model are compiled first.
*/
`timescale 1ns/1ps
`include "pms_consts.svh"
module power_mode_sequencer_tb;
	logic mclk, rst, external_reset_pin_n, sleep_exec, ccr_i_mask;
	logic dt_irq_enable, periph_irq_req;
	logic [3:0] external_irq_inputs;
	logic [5:0] wakeup_inputs;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] mode;
	logic chip_reset, main_osc_en, sub_osc_en, cpu_run, port_hiz, rtc_run;
	logic wdt_run, periph_reset, dt_exc_req, wake_exc_req;
	logic [9:0] wake_pins;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	localparam logic [3:0] HC [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
	localparam pms_pkg::pms_state_t HM [6] = '{pms_pkg::PMS_SLEEP,
		pms_pkg::PMS_SUBSLEEP, pms_pkg::PMS_SLEEP, pms_pkg::PMS_SUBSLEEP,
		pms_pkg::PMS_STANDBY, pms_pkg::PMS_STANDBY};

	pms_top pms_top_i (.mclk, .rst, .external_reset_pin_n,
		.external_irq_inputs, .wakeup_inputs, .sleep_exec, .ccr_i_mask,
		.dt_irq_enable, .periph_irq_req, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode, .chip_reset,
		.main_osc_en, .sub_osc_en, .cpu_run, .port_hiz, .rtc_run, .wdt_run,
		.periph_reset, .dt_exc_req, .wake_exc_req, .wake_pins);
	pms_cpu_model pms_cpu_model_i (.mclk, .cpu_run, .sleep_exec,
		.ccr_i_mask, .dt_irq_enable, .periph_irq_req);

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk

	task tally_and_finish;
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_on;
		logic w_on;
		aw_on = 1'b1;
		w_on = 1'b1;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_on || w_on)
		begin
			@(posedge mclk);
			if (aw_on && s_axi_awready === 1'b1)
			begin
				aw_on = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_on && s_axi_wready === 1'b1)
			begin
				w_on = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, r);
	endtask : axi_wr

	task axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge mclk);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk("rresp", s_axi_rresp, r);
	endtask : axi_rd

	// Program the control word, execute SLEEP, judge the new mode
	task sleep_to(input logic [31:0] c, input logic [2:0] e, input logic dt);
		axi_wr(`PMS_ADDR_CTRL, c, `PMS_RESP_OKAY);
		pms_cpu_model_i.exec_sleep();
		#1;
		chk("mode", mode, e);
		chk("dt_exc", dt_exc_req, dt);
	endtask : sleep_to

	task wait_mode(input logic [2:0] e);
		int n;
		n = 0;
		while (mode !== e && n < 10)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("mode", mode, e);
	endtask : wait_mode

	task t_regs;
		#1;
		chk("rst_mode", mode, pms_pkg::PMS_ACTIVE);
		axi_rd(`PMS_ADDR_CTRL, rd, `PMS_RESP_OKAY);
		chk("ctrl", rd, 32'h0);
		axi_rd(`PMS_ADDR_WAKE_EN, rd, `PMS_RESP_OKAY);
		chk("wake_en", rd, 32'h0);
		axi_rd(`PMS_ADDR_STATUS, rd, `PMS_RESP_OKAY);
		chk("status", rd, 32'h1b0);
		axi_rd(4'hc, rd, `PMS_RESP_SLVERR);
		chk("unmapped", rd, 32'h0);
		axi_wr(4'hc, 32'h1, `PMS_RESP_SLVERR);
		axi_wr(`PMS_ADDR_STATUS, 32'h7, `PMS_RESP_OKAY);
		axi_wr(`PMS_ADDR_CTRL, 32'h2a, `PMS_RESP_OKAY);
		axi_rd(`PMS_ADDR_CTRL, rd, `PMS_RESP_OKAY);
		chk("ctrl_rw", rd, 32'h2a);
	endtask : t_regs

	task t_halt;
		logic [2:0] r;
		for (int i = 0; i < 6; i++)
		begin
			r = (HC[i][1] && !HC[i][3]) ? 3'h2 : 3'h0;
			sleep_to({28'h0, HC[i]}, HM[i], 1'b0);
			chk("osc", main_osc_en, HM[i] == pms_pkg::PMS_SLEEP);
			chk("run", {sub_osc_en, cpu_run}, 2'b10);
			chk("hiz", port_hiz, HM[i] == pms_pkg::PMS_STANDBY);
			chk("rtc", rtc_run, HM[i] == pms_pkg::PMS_SLEEP);
			chk("prst", periph_reset, HC[i][0]);
			pms_cpu_model_i.raise_irq(1);
			#1;
			chk("resume", mode, r);
			chk("wexc", wake_exc_req, 1'b1);
			chk("prst2", periph_reset, HC[i][0]);
			if (r != 3'h0)
				sleep_to(32'h4, pms_pkg::PMS_ACTIVE, 1'b1);
		end
	endtask : t_halt

	task t_direct;
		sleep_to(32'h4, pms_pkg::PMS_ACTIVE, 1'b1);
		sleep_to(32'h36, pms_pkg::PMS_SUBACTIVE, 1'b1);
		chk("sub_en", {main_osc_en, cpu_run, rtc_run, wdt_run}, 4'h7);
		sleep_to(32'h6, pms_pkg::PMS_SUBACTIVE, 1'b1);
		chk("sub_en2", {main_osc_en, cpu_run, rtc_run, wdt_run}, 4'h4);
		sleep_to(32'h4, pms_pkg::PMS_ACTIVE, 1'b1);
		pms_cpu_model_i.set_flags(1'b0, 1'b0);
		sleep_to(32'h4, pms_pkg::PMS_SLEEP, 1'b0);
		pms_cpu_model_i.raise_irq(1);
		pms_cpu_model_i.set_flags(1'b1, 1'b1);
		sleep_to(32'h4, pms_pkg::PMS_SLEEP, 1'b0);
		pms_cpu_model_i.raise_irq(4);
		#1;
		chk("masked", mode, pms_pkg::PMS_SLEEP);
		pms_cpu_model_i.set_flags(1'b0, 1'b1);
		pms_cpu_model_i.raise_irq(1);
		#1;
		chk("unmasked", mode, pms_pkg::PMS_ACTIVE);
	endtask : t_direct

	task t_pins;
		axi_wr(`PMS_ADDR_WAKE_EN, 32'h11, `PMS_RESP_OKAY);
		sleep_to(32'h0, pms_pkg::PMS_SLEEP, 1'b0);
		@(posedge mclk);
		wakeup_inputs <= 6'h02;
		repeat (6) @(posedge mclk);
		#1;
		chk("not_en", mode, pms_pkg::PMS_SLEEP);
		chk("pins", wake_pins, 10'h020);
		@(posedge mclk);
		wakeup_inputs <= 6'h03;
		wait_mode(pms_pkg::PMS_ACTIVE);
		chk("wexc", wake_exc_req, 1'b1);
		@(posedge mclk);
		wakeup_inputs <= 6'h00;
		sleep_to(32'h8, pms_pkg::PMS_STANDBY, 1'b0);
		@(posedge mclk);
		external_irq_inputs <= 4'h1;
		wait_mode(pms_pkg::PMS_ACTIVE);
		@(posedge mclk);
		external_irq_inputs <= 4'h0;
	endtask : t_pins

	task t_reset;
		sleep_to(32'h6, pms_pkg::PMS_SUBACTIVE, 1'b1);
		@(posedge mclk);
		external_reset_pin_n <= 1'b0;
		wait_mode(pms_pkg::PMS_RESET);
		chk("chip_rst", {chip_reset, main_osc_en}, 2'b11);
		@(posedge mclk);
		external_reset_pin_n <= 1'b1;
		wait_mode(pms_pkg::PMS_ACTIVE);
		chk("chip_rst0", chip_reset, 1'b0);
	endtask : t_reset

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			tally_and_finish;
		end
	end

	initial
	begin
		rst = 1'b1;
		external_reset_pin_n = 1'b1;
		external_irq_inputs = 4'h0;
		wakeup_inputs = 6'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		pms_cpu_model_i.set_flags(1'b0, 1'b1);
		t_regs;
		t_halt;
		t_direct;
		t_pins;
		t_reset;
		tally_and_finish;
	end
endmodule : power_mode_sequencer_tb
